//--- rtl/otp_ecc_store.sv
`timescale 1ns/1ps
module otp_ecc_store
    import reset_fault_pkg::*;
#(
    parameter logic [OTP_WORDS*8-1:0] CONTENT = '0,
    parameter logic [OTP_WORDS*CODE_W-1:0] FLIP = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic rd_en,
    input wire logic [1:0] rd_addr,
    output logic [7:0] rd_data,
    output logic corrected
);
    typedef struct packed {
        logic [7:0] data;
        logic corr;
    } otp_state_t;

    otp_state_t cur;
    otp_state_t next_cur;

    // hamming code, parity at positions 1, 2, 4 and 8
    function automatic logic [CODE_W-1:0] encode(input logic [7:0] d);
        logic [CODE_W:1] c;
        int k;
        c = '0;
        k = 0;
        for (int pos = 1; pos <= CODE_W; pos++) begin
            if ((pos & (pos - 1)) != 0) begin
                c[pos] = d[k];
                k++;
            end
        end
        for (int p = 1; p <= 8; p = p * 2) begin
            for (int pos = 3; pos <= CODE_W; pos++) begin
                if ((pos & p) != 0 && pos != p) begin
                    c[p] = c[p] ^ c[pos];
                end
            end
        end
        return c;
    endfunction : encode

    // returns {corrected, data}; a single flipped bit is repaired
    function automatic logic [8:0] decode(input logic [CODE_W-1:0] w);
        logic [CODE_W:1] c;
        logic [3:0] syn;
        logic [7:0] d;
        int k;
        c = w;
        syn = '0;
        d = '0;
        k = 0;
        for (int pos = 1; pos <= CODE_W; pos++) begin
            if (c[pos]) begin
                syn = syn ^ 4'(pos);
            end
        end
        if (syn != 4'h0 && syn <= 4'(CODE_W)) begin
            c[syn] = ~c[syn];
        end
        for (int pos = 1; pos <= CODE_W; pos++) begin
            if ((pos & (pos - 1)) != 0) begin
                d[k] = c[pos];
                k++;
            end
        end
        return {syn != 4'h0, d};
    endfunction : decode

    // stored words are fixed; flip lets a test plant a bit error
    always_comb begin
        logic [CODE_W-1:0] word;
        word = '0;
        next_cur = cur;
        if (rd_en && int'(rd_addr) < OTP_WORDS) begin
            word = encode(CONTENT[int'(rd_addr)*8 +: 8])
                ^ FLIP[int'(rd_addr)*CODE_W +: CODE_W];
            {next_cur.corr, next_cur.data} = decode(word);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign rd_data = cur.data;
    assign corrected = cur.corr;
endmodule : otp_ecc_store

//--- rtl/reset_fault_pkg.sv
// Operation
// - Select bit 0: every single watchdog violation pulls the reset output low.
// - Select bit 1: reset only after two violations with no valid update between.
// - Two-violation mode: a valid update after one violation clears the counter.
// - Reset stays low after causes clear for hold 01=8ms, 10=16ms, 11=32ms.
// - Hold code 00 adds no hold; release about 6us after cause clears.
// - Read-only 8-bit chip identification register, fixed in programmable storage.
// - Every falling edge of the sequence enable input reloads configuration.
// - That reload waits until the sequence recorder has finished capturing.
// - Reload leaves recorder power-up and power-down timestamps untouched.
// - With reload-on-watchdog set, a watchdog fault also triggers a reload.
// - Each reload from programmable storage completes in about 1us.
// - Stored configuration passes single-error correction before it is used.
// - Separate indicators: parity, clock fault, enable/reset readback, self-test.
// - Stuck comparator asserts reset and sets a readable flag.
// - Each kind of watchdog violation has its own fault flag.
// - Violation counted on early update or on open window expiring.
// - Watchdog lock set: writes to the reset control register are ignored.
package reset_fault_pkg;
    // register offsets
    localparam logic [7:0] CTRL_OFS = 8'h2c;
    localparam logic [7:0] CHIPID_OFS = 8'h2d;
    localparam logic [7:0] STUCK_OFS = 8'h2e;
    localparam logic [7:0] DIAG_OFS = 8'h2f;
    localparam logic [7:0] FAULTCFG_OFS = 8'h30;
    // field positions
    localparam int DBL_BIT = 2;
    localparam int CTRL_W = 3;
    localparam int RELOAD_WD_BIT = 0;
    localparam int PARITY_BIT = 0;
    localparam int CLKF_BIT = 1;
    localparam int ENRB_BIT = 2;
    localparam int RSTRB_BIT = 3;
    localparam int BIST_BIT = 4;
    localparam int EARLY_BIT = 5;
    localparam int EXPIRED_BIT = 6;
    // values after reset
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [7:0] CHIP_ID_RST = 8'h00;
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int HOLD_UNIT_MS = 8;
    localparam int HOLD_UNIT_CYC = HOLD_UNIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int INTR_HOLD_NS = 6000;
    localparam int INTR_HOLD_CYC = INTR_HOLD_NS / CLK_PERIOD_NS;
    localparam int RELOAD_NS = 1000;
    localparam int RELOAD_CYC = RELOAD_NS / CLK_PERIOD_NS;
    localparam int HOLD_W = 21;
    localparam int LD_W = 6;
    // programmable storage map
    localparam int OTP_WORDS = 3;
    localparam int CODE_W = 12;
    localparam int STUCK_FLAGS_W = 6;
    typedef enum logic [1:0] {MODE_IDLE, MODE_WAIT_REC, MODE_LOAD} reload_mode_t;
endpackage : reset_fault_pkg

//--- rtl/reset_output_fault_reaction.sv
`timescale 1ns/1ps
module reset_output_fault_reaction
    import reset_fault_pkg::*;
#(
    parameter int HOLD_UNIT_CYCLES = HOLD_UNIT_CYC,
    parameter int STUCK_W = STUCK_FLAGS_W,
    // stored configuration; identification value is arbitrary
    parameter logic [7:0] OTP_CTRL = 8'h01,
    parameter logic [7:0] OTP_CHIP_ID = 8'h5a,
    parameter logic [7:0] OTP_CFG = 8'h00,
    parameter logic [OTP_WORDS*CODE_W-1:0] OTP_FLIP = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic seq_enable_input,
    input wire logic reset_pin_in,
    input wire logic recorder_done,
    input wire logic wd_update_valid,
    input wire logic wd_early_update,
    input wire logic wd_window_expired,
    input wire logic wd_lock,
    input wire logic [STUCK_W-1:0] comparator_stuck,
    input wire logic parity_fault,
    input wire logic clock_fault,
    input wire logic bist_fail,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reset_out_b,
    output logic reload_busy,
    output logic otp_corrected
);
    typedef struct packed {
        logic en_s1;
        logic en_s2;
        logic en_q;
        logic rp_s1;
        logic rp_s2;
        reload_mode_t mode;
        logic [LD_W-1:0] ld_cnt;
        logic viol_cnt;
        logic [HOLD_W-1:0] hold_cnt;
        logic rst_out_b;
        logic [CTRL_W-1:0] ctrl;
        logic [7:0] chip_id;
        logic reload_wd;
        logic [STUCK_W-1:0] stuck;
        logic early_flag;
        logic exp_flag;
        logic [7:0] rdata;
        logic corr;
    } state_t;

    // hold lengths in clock cycles per hold code
    localparam logic [HOLD_W-1:0] HL0 = HOLD_W'(INTR_HOLD_CYC);
    localparam logic [HOLD_W-1:0] HL1 = HOLD_W'(HOLD_UNIT_CYCLES);
    localparam logic [HOLD_W-1:0] HL2 = HOLD_W'(HOLD_UNIT_CYCLES * 2);
    localparam logic [HOLD_W-1:0] HL3 = HOLD_W'(HOLD_UNIT_CYCLES * 4);
    localparam logic [LD_W-1:0] LD_LAST = LD_W'(RELOAD_CYC - 1);
    localparam logic [LD_W-1:0] LD_WORDS = LD_W'(OTP_WORDS);

    state_t cur;
    state_t next_cur;
    logic viol;
    logic wd_trip;
    logic cause;
    logic en_fell;
    logic [HOLD_W-1:0] hold_len;
    logic otp_rd_en;
    logic [1:0] otp_addr;
    logic [1:0] cap_addr;
    logic [7:0] otp_data;
    logic otp_corr;
    logic [7:0] diag;
    logic ctrl_wr_ok;

    // either violation kind counts alike
    assign viol = wd_early_update | wd_window_expired;
    // single mode trips at once, double mode on the second in a row
    assign wd_trip = viol && (!cur.ctrl[DBL_BIT]
        || cur.viol_cnt);
    // every reset cause; stuck comparators pull reset too
    assign cause = wd_trip | (|comparator_stuck)
        | parity_fault | clock_fault;
    // edge taken on synchronised copies only
    assign en_fell = cur.en_q & ~cur.en_s2;
    assign ctrl_wr_ok = reg_wr && reg_addr == CTRL_OFS
        && !wd_lock;
    assign otp_rd_en = cur.mode == MODE_LOAD && cur.ld_cnt < LD_WORDS;
    assign otp_addr = cur.ld_cnt[1:0];
    assign cap_addr = 2'(cur.ld_cnt - 1'b1);

    // live readback of fault inputs and pins next to sticky flags
    always_comb begin
        diag = '0;
        diag[PARITY_BIT] = parity_fault;
        diag[CLKF_BIT] = clock_fault;
        diag[ENRB_BIT] = cur.en_s2;
        diag[RSTRB_BIT] = cur.rp_s2;
        diag[BIST_BIT] = bist_fail;
        diag[EARLY_BIT] = cur.early_flag;
        diag[EXPIRED_BIT] = cur.exp_flag;
    end

    // hold time selected by the two-bit field
    always_comb begin
        case (cur.ctrl[1:0])
            2'h0: hold_len = HL0;
            2'h1: hold_len = HL1;
            2'h2: hold_len = HL2;
            2'h3: hold_len = HL3;
            default: hold_len = HL0;
        endcase
    end

    otp_ecc_store #(
        .CONTENT({OTP_CFG, OTP_CHIP_ID, OTP_CTRL}),
        .FLIP(OTP_FLIP)
    ) u_otp (
        .clk(clk),
        .rst_b(rst_b),
        .rd_en(otp_rd_en),
        .rd_addr(otp_addr),
        .rd_data(otp_data),
        .corrected(otp_corr)
    );

    // all next-state logic of the block
    always_comb begin
        next_cur = cur;
        // pins pass two flops before anything looks at them
        next_cur.en_s1 = seq_enable_input;
        next_cur.en_s2 = cur.en_s1;
        next_cur.en_q = cur.en_s2;
        next_cur.rp_s1 = reset_pin_in;
        next_cur.rp_s2 = cur.rp_s1;

        // violation counter; the trip itself restarts counting
        if (wd_trip) begin
            next_cur.viol_cnt = 1'b0;
        end else if (viol) begin
            next_cur.viol_cnt = 1'b1;
        end else if (wd_update_valid) begin
            next_cur.viol_cnt = 1'b0;
        end

        // hold counter restarts while any cause is present
        if (cause) begin
            next_cur.hold_cnt = hold_len;
        end else if (cur.hold_cnt != '0) begin
            next_cur.hold_cnt = cur.hold_cnt - 1'b1;
        end
        next_cur.rst_out_b = !(cause || cur.hold_cnt != '0);

        // sticky flags; a new event beats the clear by read
        if (reg_rd && reg_addr == STUCK_OFS) begin
            next_cur.stuck = '0;
        end
        next_cur.stuck = next_cur.stuck | comparator_stuck;
        if (reg_rd && reg_addr == DIAG_OFS) begin
            next_cur.early_flag = 1'b0;
            next_cur.exp_flag = 1'b0;
        end
        next_cur.early_flag = next_cur.early_flag | wd_early_update;
        next_cur.exp_flag = next_cur.exp_flag | wd_window_expired;

        // register writes; a reload capture of the same register in this cycle overrides them below
        if (ctrl_wr_ok) begin
            next_cur.ctrl = reg_wdata[CTRL_W-1:0];
        end
        if (reg_wr && reg_addr == FAULTCFG_OFS) begin
            next_cur.reload_wd = reg_wdata[RELOAD_WD_BIT];
        end

        // read data held until the next read
        if (reg_rd) begin
            case (reg_addr)
                CTRL_OFS: next_cur.rdata = {5'h00, cur.ctrl};
                CHIPID_OFS: next_cur.rdata = cur.chip_id;
                STUCK_OFS: next_cur.rdata = 8'(cur.stuck);
                DIAG_OFS: next_cur.rdata = diag;
                FAULTCFG_OFS: next_cur.rdata = {7'h00, cur.reload_wd};
                default: next_cur.rdata = 8'h00;
            endcase
        end

        // reload sequencer
        case (cur.mode)
            MODE_IDLE: begin
                if (wd_trip && cur.reload_wd) begin
                    next_cur.mode = MODE_LOAD;
                    next_cur.ld_cnt = '0;
                end
            end
            MODE_WAIT_REC: begin
                // recorder must finish the power-down capture first
                if (recorder_done) begin
                    next_cur.mode = MODE_LOAD;
                    next_cur.ld_cnt = '0;
                end
            end
            MODE_LOAD: begin
                next_cur.ld_cnt = cur.ld_cnt + 1'b1;
                // storage answers one cycle after the address
                if (cur.ld_cnt != '0 && cur.ld_cnt <= LD_WORDS) begin
                    next_cur.corr = cur.corr | otp_corr;
                    // only these words; recorder timestamps live elsewhere
                    case (cap_addr)
                        2'h0: next_cur.ctrl = otp_data[CTRL_W-1:0];
                        2'h1: next_cur.chip_id = otp_data;
                        2'h2: next_cur.reload_wd = otp_data[RELOAD_WD_BIT];
                        default: next_cur.corr = next_cur.corr;
                    endcase
                end
                // fixed length keeps the reload time predictable
                if (cur.ld_cnt == LD_LAST) begin
                    next_cur.mode = MODE_IDLE;
                end
            end
            default: next_cur.mode = MODE_IDLE;
        endcase
        // a falling enable always restarts, even mid-reload
        if (en_fell) begin
            next_cur.mode = MODE_WAIT_REC;
            next_cur.ld_cnt = '0;
        end
    end

    // reset starts with the power-up reload and reset held low
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur <= '0;
            cur.mode <= MODE_LOAD;
            cur.ctrl <= CTRL_RST;
            cur.chip_id <= CHIP_ID_RST;
        end else begin
            cur <= next_cur;
        end
    end

    assign reg_rdata = cur.rdata;
    assign reset_out_b = cur.rst_out_b;
    assign reload_busy = cur.mode != MODE_IDLE;
    assign otp_corrected = cur.corr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_single_viol_reset: assert property (
        (viol && !cur.ctrl[DBL_BIT]) |=> !reset_out_b
    ) else $error("single violation did not pull reset low");

    a_double_first_held: assert property (
        (viol && cur.ctrl[DBL_BIT] && !cur.viol_cnt)
        |-> (!wd_trip ##1 cur.viol_cnt)
    ) else $error("first violation in double mode tripped");

    a_double_second_trip: assert property (
        (viol && cur.ctrl[DBL_BIT] && cur.viol_cnt)
        |=> (!reset_out_b && !cur.viol_cnt)
    ) else $error("second violation did not assert reset");

    a_update_clears: assert property (
        (wd_update_valid && !viol) |=> !cur.viol_cnt
    ) else $error("valid update left violation count");

    a_hold_8ms: assert property (
        (cause && cur.ctrl[1:0] == 2'h1 && cur.mode == MODE_IDLE
            && !en_fell)
        |=> (cur.hold_cnt == HL1 && !reset_out_b)
    ) else $error("hold time not loaded for code 01");

    a_hold_release: assert property (
        (!cause && cur.hold_cnt == 21'h000001) |=> (!reset_out_b
            ##1 (reset_out_b || $past(cause)))
    ) else $error("reset not released at end of hold");

    a_intr_hold: assert property (
        (cause && cur.ctrl[1:0] == 2'h0 && cur.mode == MODE_IDLE
            && !en_fell)
        |=> cur.hold_cnt == HL0
    ) else $error("interrupt style hold not 6us");

    a_chip_id_steady: assert property (
        (cur.mode == MODE_IDLE) |=> $stable(cur.chip_id)
    ) else $error("chip id changed outside reload");

    a_enable_fall: assert property (
        en_fell |=> (cur.mode == MODE_WAIT_REC && reload_busy)
    ) else $error("falling enable did not start reload");

    a_wait_recorder: assert property (
        (cur.mode == MODE_WAIT_REC && !recorder_done)
        |=> cur.mode == MODE_WAIT_REC
    ) else $error("reload began before recorder finished");

    a_wd_reload: assert property (
        (cur.mode == MODE_IDLE && wd_trip && cur.reload_wd && !en_fell)
        |=> (cur.mode == MODE_LOAD && cur.ld_cnt == '0)
    ) else $error("watchdog fault did not trigger reload");

    a_reload_length: assert property (
        (cur.mode == MODE_LOAD && cur.ld_cnt == LD_LAST && !en_fell)
        |=> (cur.mode == MODE_IDLE)
    ) else $error("reload did not end after 1us");

    a_stuck_flag: assert property (
        (|comparator_stuck) |=> (!reset_out_b
            && (cur.stuck & $past(comparator_stuck)) != '0)
    ) else $error("stuck comparator not flagged");

    a_kind_flags: assert property (
        (wd_early_update && !wd_window_expired)
        |=> (cur.early_flag ##0 $stable(cur.exp_flag)
            || $past(reg_rd))
    ) else $error("early update flag not set alone");

    a_lock_ignore: assert property (
        (reg_wr && reg_addr == CTRL_OFS && wd_lock
            && cur.mode != MODE_LOAD && !en_fell)
        |=> $stable(cur.ctrl)
    ) else $error("locked control register was written");

    a_trip_clears: assert property (
        wd_trip |=> !cur.viol_cnt
    ) else $error("watchdog reset kept violation count");
endmodule : reset_output_fault_reaction

//--- verif/supervisor_model.sv
`timescale 1ns/1ps
// host side of the register port plus the reset pin readback
module supervisor_model (
    input wire logic clk,
    input wire logic reset_out_b,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    output logic reset_pin_in
);
    // readback follows the line, no board delay modelled
    assign reset_pin_in = reset_out_b;

    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // idle bus shows inverted values so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    // data is taken one and a half cycles after the request edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd
endmodule : supervisor_model

//--- verif/test_reset_output_fault_reaction.sv
`timescale 1ns/1ps
module test_reset_output_fault_reaction;
    import reset_fault_pkg::*;
    // short hold unit keeps the run small
    localparam int UNIT = 50;
    localparam logic [7:0] STORED_ID = 8'h3c; // arbitrary value
    localparam logic [7:0] STORED_CTRL = 8'h01;
    localparam logic [7:0] STORED_CFG = 8'h00;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic seq_enable_input = 1'b1;
    logic recorder_done = 1'b0;
    logic wd_update_valid = 1'b0;
    logic wd_early_update = 1'b0;
    logic wd_window_expired = 1'b0;
    logic wd_lock = 1'b0;
    logic parity_fault = 1'b0;
    logic clock_fault = 1'b0;
    logic bist_fail = 1'b0;
    logic [5:0] comparator_stuck = 6'h00;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic reg_wr, reg_rd, reset_pin_in, reset_out_b, reload_busy;
    logic otp_corrected;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    int n;

    always #12.5 clk = ~clk;

    // one flipped bit in the stored chip id word
    reset_output_fault_reaction #(
        .HOLD_UNIT_CYCLES(UNIT),
        .OTP_CTRL(STORED_CTRL),
        .OTP_CHIP_ID(STORED_ID),
        .OTP_CFG(STORED_CFG),
        .OTP_FLIP(36'h000010000)
    ) DUT (
        .clk(clk),
        .rst_b(rst_b),
        .seq_enable_input(seq_enable_input),
        .reset_pin_in(reset_pin_in),
        .recorder_done(recorder_done),
        .wd_update_valid(wd_update_valid),
        .wd_early_update(wd_early_update),
        .wd_window_expired(wd_window_expired),
        .wd_lock(wd_lock),
        .comparator_stuck(comparator_stuck),
        .parity_fault(parity_fault),
        .clock_fault(clock_fault),
        .bist_fail(bist_fail),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reset_out_b(reset_out_b),
        .reload_busy(reload_busy),
        .otp_corrected(otp_corrected)
    );

    supervisor_model host (
        .clk(clk),
        .reset_out_b(reset_out_b),
        .reg_rdata(reg_rdata),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reset_pin_in(reset_pin_in)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // 0 early update, 1 window expired, 2 valid update
    task automatic pulse(input int k);
        @(negedge clk);
        case (k)
            0: wd_early_update = 1'b1;
            1: wd_window_expired = 1'b1;
            default: wd_update_valid = 1'b1;
        endcase
        @(negedge clk);
        wd_early_update = 1'b0;
        wd_window_expired = 1'b0;
        wd_update_valid = 1'b0;
    endtask : pulse

    // cycles the reset output stays low, bounded
    task automatic count_low(output int c);
        c = 0;
        while (reset_out_b === 1'b0 && c < 1000) begin
            c++;
            @(negedge clk);
        end
    endtask : count_low

    task automatic wait_busy(output int c);
        c = 0;
        while (reload_busy !== 1'b0 && c < 200) begin
            @(negedge clk);
            c++;
        end
    endtask : wait_busy

    task automatic t_reset_values();
        wait_busy(n);
        check(n <= 44, 1);
        check(otp_corrected, 1);
        host.rd(CHIPID_OFS, rd);
        check(rd, STORED_ID);
        host.rd(CTRL_OFS, rd);
        check(rd, STORED_CTRL);
        check(reset_out_b, 1);
    endtask : t_reset_values

    task automatic t_hold_codes();
        for (int c = 0; c < 4; c++) begin
            host.wr(CTRL_OFS, 8'(c));
            pulse(1);
            count_low(n);
            check(n, c == 0 ? INTR_HOLD_CYC + 1 : (UNIT << (c - 1)) + 1);
        end
    endtask : t_hold_codes

    // two-violation mode, flags per violation kind
    task automatic t_double();
        host.wr(CTRL_OFS, 8'h05);
        host.rd(DIAG_OFS, rd);
        pulse(0);
        host.rd(DIAG_OFS, rd);
        check(rd, 8'h2c);
        check(reset_out_b, 1);
        pulse(2);
        pulse(1);
        host.rd(DIAG_OFS, rd);
        check(rd, 8'h4c);
        check(reset_out_b, 1);
        pulse(0);
        count_low(n);
        check(n, UNIT + 1);
        pulse(0);
        repeat (2) @(negedge clk);
        check(reset_out_b, 1);
        pulse(1);
        count_low(n);
        check(n, UNIT + 1);
    endtask : t_double

    task automatic t_lock();
        wd_lock = 1'b1;
        host.wr(CTRL_OFS, 8'h03);
        host.rd(CTRL_OFS, rd);
        check(rd, 8'h05);
        wd_lock = 1'b0;
        host.wr(CHIPID_OFS, 8'hff);
        host.rd(CHIPID_OFS, rd);
        check(rd, STORED_ID);
        host.rd(8'h7f, rd);
        check(rd, 8'h00);
    endtask : t_lock

    task automatic t_stuck();
        comparator_stuck = 6'h08;
        repeat (2) @(negedge clk);
        check(reset_out_b, 0);
        comparator_stuck = 6'h00;
        host.rd(STUCK_OFS, rd);
        check(rd, 8'h08);
        host.rd(STUCK_OFS, rd);
        check(rd, 8'h00);
        count_low(n);
        check(reset_out_b, 1);
    endtask : t_stuck

    task automatic t_diag();
        host.rd(DIAG_OFS, rd);
        parity_fault = 1'b1;
        bist_fail = 1'b1;
        repeat (3) @(negedge clk);
        host.rd(DIAG_OFS, rd);
        check(rd, 8'h15);
        parity_fault = 1'b0;
        bist_fail = 1'b0;
        clock_fault = 1'b1;
        repeat (2) @(negedge clk);
        host.rd(DIAG_OFS, rd);
        check(rd, 8'h06);
        clock_fault = 1'b0;
        count_low(n);
        repeat (4) @(negedge clk);
        host.rd(DIAG_OFS, rd);
        check(rd, 8'h0c);
    endtask : t_diag

    // reload must wait for the recorder, then restore stored values
    task automatic t_enable_reload();
        host.wr(CTRL_OFS, 8'h07);
        seq_enable_input = 1'b0;
        repeat (10) @(negedge clk);
        check(reload_busy, 1);
        host.rd(CTRL_OFS, rd);
        check(rd, 8'h07);
        recorder_done = 1'b1;
        wait_busy(n);
        check(n >= 38 && n <= 44, 1);
        host.rd(CTRL_OFS, rd);
        check(rd, STORED_CTRL);
        seq_enable_input = 1'b1;
        recorder_done = 1'b0;
    endtask : t_enable_reload

    task automatic t_wd_reload();
        host.wr(FAULTCFG_OFS, 8'h01);
        host.rd(FAULTCFG_OFS, rd);
        check(rd, 8'h01);
        host.wr(CTRL_OFS, 8'h02);
        pulse(1);
        @(negedge clk);
        check(reload_busy, 1);
        wait_busy(n);
        check(n <= 44, 1);
        host.rd(CTRL_OFS, rd);
        check(rd, STORED_CTRL);
        host.rd(FAULTCFG_OFS, rd);
        check(rd, STORED_CFG);
        count_low(n);
        check(reset_out_b, 1);
    endtask : t_wd_reload

    task summarize();
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            $display("Error %0t: timeout", $time);
            summarize();
        end
    end

    initial begin
        repeat (10) @(negedge clk);
        check(reset_out_b, 0);
        rst_b = 1'b1;
        t_reset_values();
        t_hold_codes();
        t_double();
        t_lock();
        t_stuck();
        t_diag();
        t_enable_reload();
        t_wd_reload();
        summarize();
    end
endmodule : test_reset_output_fault_reaction
